// ==== logic/nsr_pkg.sv ====
package nsr_pkg;

	// ---------------------------------------------------------------
	// timing
	// ---------------------------------------------------------------
	localparam int CLK_MHZ     = 20;
	localparam int T_STROBE_NS = 50;
	localparam int T_WB_NS     = 100;
	localparam int T_CCS_NS    = 70;
	localparam int STROBE_CYC  = (T_STROBE_NS * CLK_MHZ + 999) / 1000;
	localparam int WB_CYC      = (T_WB_NS * CLK_MHZ + 999) / 1000;
	localparam int CCS_CYC     = (T_CCS_NS * CLK_MHZ + 999) / 1000;

	// ---------------------------------------------------------------
	// device commands
	// ---------------------------------------------------------------
	localparam logic [7:0] CMD_READ_MODE  = 8'h00;
	localparam logic [7:0] CMD_COLCHG     = 8'h05;
	localparam logic [7:0] CMD_COLCHG_END = 8'he0;
	localparam logic [7:0] CMD_STATUS     = 8'h70;
	localparam logic [7:0] CMD_STATUS_ENH = 8'h78;
	localparam logic [7:0] CMD_PARAM      = 8'hec;
	localparam logic [7:0] CMD_UID        = 8'hed;
	localparam logic [7:0] ADDR_ZERO      = 8'h00;

	localparam logic [1:0] ENH_ROW_CYC = 2'h3;
	localparam logic [1:0] COL_CYC     = 2'h2;
	localparam logic [1:0] ONE_CYC     = 2'h1;

	// ---------------------------------------------------------------
	// user operations
	// ---------------------------------------------------------------
	typedef enum logic [2:0] {
		OP_STATUS     = 3'h0,
		OP_STATUS_ENH = 3'h1,
		OP_PARAM      = 3'h2,
		OP_UID        = 3'h3,
		OP_COLCHG     = 3'h4,
		OP_READ_MODE  = 3'h5
	} nsr_op_t;

	typedef enum logic [6:0] {
		S_IDLE   = 7'h01,
		S_CMD1   = 7'h02,
		S_ADDR   = 7'h04,
		S_CMD2   = 7'h08,
		S_WAITT  = 7'h10,
		S_WAITRB = 7'h20,
		S_READ   = 7'h40
	} nsr_state_t;

	// ---------------------------------------------------------------
	// status word fields
	// ---------------------------------------------------------------
	localparam int         SB_FAIL      = 0;
	localparam int         SB_PERR      = 1;
	localparam int         SB_RDY_A     = 5;
	localparam int         SB_RDY_B     = 6;
	localparam int         SB_WP_N      = 7;
	localparam logic [7:0] SB_ZERO_MASK = 8'h1c;

	// ---------------------------------------------------------------
	// parameter page fields checked, lsb first, offset within a copy
	// ---------------------------------------------------------------
	localparam int PP_N = 19;
	localparam logic [7:0] PP_OFS [PP_N] = '{
		8'h54, 8'h55, 8'h56, 8'h57, 8'h58, 8'h59, 8'h64, 8'h67, 8'h68, 8'h6b,
		8'h71, 8'h85, 8'h86, 8'h87, 8'h88, 8'h89, 8'h8a, 8'h8b, 8'h8c};
	localparam logic [7:0] PP_VAL [PP_N] = '{
		8'h40, 8'h00, 8'h00, 8'h02, 8'h00, 8'h00, 8'h02, 8'h50, 8'h00, 8'h01,
		8'h01, 8'hbc, 8'h02, 8'h10, 8'h27, 8'h19, 8'h00, 8'h46, 8'h00};

	// ---------------------------------------------------------------
	// unique id layout
	// ---------------------------------------------------------------
	localparam int         UID_LEN     = 16;
	localparam logic [4:0] UID_PAIR_LAST = 5'h1f;

endpackage : nsr_pkg

// ==== logic/nsr_tick.sv ====
module nsr_tick
	import nsr_pkg::*;
#(
	parameter int DIV = STROBE_CYC
) (
	input  wire logic mclk_i,    // system clock
	input  wire logic reset_n_i, // async reset, active low
	output logic      tick_o     // one-cycle enable every DIV cycles
);

	logic [15:0] cnt_r;

	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			cnt_r  <= 16'h0;
			tick_o <= 1'b0;
		end else if (cnt_r == 16'(DIV - 1)) begin
			cnt_r  <= 16'h0;
			tick_o <= 1'b1;
		end else begin
			cnt_r  <= cnt_r + 16'h1;
			tick_o <= 1'b0;
		end
	end

endmodule // nsr_tick

// ==== logic/nsr_host.sv ====
// Operation
// [RL1] spare bytes per page at 84-85 read 40h,00h
// [RL2] partial page data bytes 86-89 are 00h,02h,00h,00h; spare at 90-91
// [RL3] pages per block 92-95, blocks per unit 96-99, two units at 100
// [RL4] bad block max 103-104 is 50h,00h; one good block at 107
// [RL5] byte 113 reports one plane address bit, 01h
// [RL6] program time BCh,02h at 133-134; erase time 10h,27h at 135-136
// [RL7] random read 19h,00h at 137-138; column change setup 46h,00h at 139-140
// [RL8] parameter bytes repeat every 256 bytes
// [RL9] wide devices carry the defined value on the low byte lanes
// [RL10] 8-bit status word readable while busy, selected by 70h
// [RL11] after 70h each read returns status on data lines 7:0
// [RL12] status mode holds until next command; 00h restarts array output at column zero
// [RL13] status bit 0 flags program or erase failure
// [RL14] status bit 1 flags program error
// [RL15] status bits 5 and 6 read one when ready
// [RL16] status bit 7 reads one when not write protected
// [RL17] 78h returns status of the addressed plane even when busy
// [RL18] 78h takes three row cycles; status mode holds until next command
// [RL19] enhanced ready bits shared, result bits per addressed plane
// [RL20] after enhanced status issue 00h before array reads
// [RL21] never issue 78h while the one-time-programmable mode is on
// [RL22] unique id page: 16 code bytes then complement, sixteen times
// [RL23] accept a uid copy only if code xor complement is all ones
// [RL24] column change 05h-E0h allowed during parameter page output
// [RL25] status bits 2-4 read zero; multi-byte fields lsb first
module nsr_host
	import nsr_pkg::*;
#(
	parameter int IO_W = 8
) (
	input  wire logic            mclk_i,         // system clock
	input  wire logic            reset_n_i,      // async reset, active low
	input  wire logic            req_valid_i,    // request strobe
	input  wire logic [2:0]      req_op_i,       // operation code
	input  wire logic [23:0]     req_row_i,      // row address for enhanced status
	input  wire logic [15:0]     req_col_i,      // column for column change
	input  wire logic [15:0]     req_len_i,      // bytes to read
	input  wire logic            otp_mode_i,     // otp mode active
	output logic                 req_ready_o,    // idle, takes a request
	output logic                 req_refused_o,  // request dropped
	output logic [7:0]           rd_data_o,      // byte read
	output logic                 rd_valid_o,     // byte strobe
	output logic [15:0]          rd_index_o,     // byte column
	output logic                 done_o,         // operation finished
	output logic [7:0]           status_o,       // last status word
	output logic                 dev_ready_o,    // both ready bits set
	output logic                 op_fail_o,      // program or erase failed
	output logic                 prog_err_o,     // program error
	output logic                 wp_off_o,       // not write protected
	output logic                 status_odd_o,   // zero bits not zero
	output logic                 param_ok_o,     // checked fields matched
	output logic                 uid_ok_o,       // uid copy accepted
	output logic [127:0]         uid_code_o,     // accepted uid
	output logic                 ce_n_o,         // chip select, low active
	output logic                 cle_o,          // command latch
	output logic                 ale_o,          // address latch
	output logic                 we_n_o,         // write strobe, low active
	output logic                 read_strobe_n_o, // read strobe, low active
	output logic                 wp_n_o,         // write protect, low active
	input  wire logic [IO_W-1:0] io_i,           // data in
	output logic [IO_W-1:0]      io_o,           // data out
	output logic                 io_oe_n_o,      // low while driving io
	input  wire logic            ready_busy_n_i  // device ready
);

	nsr_state_t  st_r;
	nsr_op_t     op_r;
	logic        tick;
	logic        ph_r;
	logic [1:0]  addr_n_r;
	logic [1:0]  addr_i_r;
	logic [23:0] row_r;
	logic [15:0] col_r;
	logic [15:0] left_r;
	logic [15:0] idx_r;
	logic [7:0]  wait_r;
	logic        rd_first_r;
	logic        status_mode_r;
	logic        param_mode_r;
	logic [7:0]  abyte;

	nsr_tick #(.DIV(STROBE_CYC)) u_tick (
		.mclk_i    (mclk_i),
		.reset_n_i (reset_n_i),
		.tick_o    (tick)
	);

	// lsb first for every multi-byte address
	always_comb begin
		case (op_r)
			OP_STATUS_ENH: abyte = row_r[{addr_i_r, 3'h0} +: 8]; // [RL18]
			OP_COLCHG:     abyte = col_r[{addr_i_r[0], 3'h0} +: 8];
			default:       abyte = ADDR_ZERO;
		endcase
	end

	// ---------------------------------------------------------------
	// sequencer
	// ---------------------------------------------------------------
	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			st_r <= S_IDLE; op_r <= OP_STATUS; ph_r <= 1'b0;
			addr_n_r <= 2'h0; addr_i_r <= 2'h0; row_r <= 24'h0; col_r <= 16'h0;
			left_r <= 16'h0; idx_r <= 16'h0; wait_r <= 8'h0; rd_first_r <= 1'b0;
			status_mode_r <= 1'b0; param_mode_r <= 1'b0;
			req_ready_o <= 1'b0; req_refused_o <= 1'b0; done_o <= 1'b0;
			rd_valid_o <= 1'b0; rd_data_o <= 8'h0; rd_index_o <= 16'h0;
			ce_n_o <= 1'b1; cle_o <= 1'b0; ale_o <= 1'b0; we_n_o <= 1'b1;
			read_strobe_n_o <= 1'b1; io_o <= '0; io_oe_n_o <= 1'b1;
		end else begin
			req_refused_o <= 1'b0;
			done_o        <= 1'b0;
			rd_valid_o    <= 1'b0;
			case (st_r)
				S_IDLE: begin
					req_ready_o <= 1'b1;
					if (req_valid_i) begin
						if ((nsr_op_t'(req_op_i) == OP_STATUS_ENH && otp_mode_i) || // [RL21]
							(nsr_op_t'(req_op_i) == OP_COLCHG && status_mode_r)) begin // [RL20]
							req_refused_o <= 1'b1;
						end else begin
							op_r <= nsr_op_t'(req_op_i);
							row_r <= req_row_i; col_r <= req_col_i;
							left_r <= req_len_i; addr_i_r <= 2'h0; ph_r <= 1'b0;
							req_ready_o <= 1'b0; ce_n_o <= 1'b0;
							st_r <= S_CMD1;
							case (nsr_op_t'(req_op_i))
								OP_STATUS, OP_READ_MODE: addr_n_r <= 2'h0;
								OP_STATUS_ENH:           addr_n_r <= ENH_ROW_CYC; // [RL18]
								OP_COLCHG:               addr_n_r <= COL_CYC;
								default:                 addr_n_r <= ONE_CYC;
							endcase
						end
					end
				end
				S_CMD1, S_ADDR, S_CMD2: if (tick) begin
					if (!ph_r) begin
						ph_r <= 1'b1; we_n_o <= 1'b0; io_oe_n_o <= 1'b0;
						cle_o <= (st_r != S_ADDR); ale_o <= (st_r == S_ADDR);
						if (st_r == S_CMD2) io_o <= IO_W'(CMD_COLCHG_END); // [RL24]
						else if (st_r == S_ADDR) io_o <= IO_W'(abyte);
						else case (op_r)
							OP_STATUS:     io_o <= IO_W'(CMD_STATUS); // [RL10]
							OP_STATUS_ENH: io_o <= IO_W'(CMD_STATUS_ENH); // [RL17]
							OP_PARAM:      io_o <= IO_W'(CMD_PARAM);
							OP_UID:        io_o <= IO_W'(CMD_UID);
							OP_COLCHG:     io_o <= IO_W'(CMD_COLCHG);
							default:       io_o <= IO_W'(CMD_READ_MODE); // [RL12]
						endcase
					end else begin
						// latches held past the rising write strobe, where the device samples them
						ph_r <= 1'b0; we_n_o <= 1'b1;
						if (st_r == S_CMD1) begin
							// any new command other than 70h or 78h leaves status mode
							status_mode_r <= (op_r == OP_STATUS || op_r == OP_STATUS_ENH); // [RL12] [RL18]
							param_mode_r  <= (op_r == OP_PARAM) || (op_r == OP_COLCHG && param_mode_r); // [RL24]
						end
						if (st_r == S_CMD1 && addr_n_r != 2'h0) st_r <= S_ADDR;
						else if (st_r == S_ADDR && addr_i_r + 2'h1 != addr_n_r) addr_i_r <= addr_i_r + 2'h1;
						else if (st_r == S_ADDR && op_r == OP_COLCHG) st_r <= S_CMD2;
						else begin
							st_r <= S_WAITT; io_oe_n_o <= 1'b1;
							// busy flag not valid until tWB has passed
							wait_r <= (op_r == OP_PARAM || op_r == OP_UID) ? 8'(WB_CYC) : 8'(CCS_CYC); // [RL7]
						end
					end
				end
				S_WAITT: begin
					cle_o <= 1'b0; ale_o <= 1'b0;
					if (wait_r > 8'h1) wait_r <= wait_r - 8'h1;
					else st_r <= (op_r == OP_PARAM || op_r == OP_UID) ? S_WAITRB : S_READ;
					idx_r <= (op_r == OP_COLCHG) ? col_r : 16'h0; // [RL12]
					rd_first_r <= 1'b1;
					if (op_r == OP_STATUS || op_r == OP_STATUS_ENH) left_r <= 16'h1;
				end
				S_WAITRB: if (ready_busy_n_i) st_r <= S_READ;
				S_READ: if (tick) begin
					if (left_r == 16'h0) begin
						st_r <= S_IDLE; ce_n_o <= 1'b1; done_o <= 1'b1;
					end else if (!ph_r) begin
						ph_r <= 1'b1; read_strobe_n_o <= 1'b0;
					end else begin
						// only the low lanes carry defined data on wide parts
						ph_r <= 1'b0; read_strobe_n_o <= 1'b1; // [RL9]
						rd_data_o <= io_i[7:0]; // [RL11]
						rd_valid_o <= 1'b1; rd_index_o <= idx_r; rd_first_r <= 1'b0;
						idx_r <= idx_r + 16'h1; left_r <= left_r - 16'h1;
					end
				end
				default: st_r <= S_IDLE;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// status word decode
	// ---------------------------------------------------------------
	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			status_o <= 8'h0; dev_ready_o <= 1'b0; op_fail_o <= 1'b0;
			prog_err_o <= 1'b0; wp_off_o <= 1'b0; status_odd_o <= 1'b0;
		end else if (rd_valid_o && (op_r == OP_STATUS || op_r == OP_STATUS_ENH)) begin
			status_o     <= rd_data_o;
			dev_ready_o  <= rd_data_o[SB_RDY_A] & rd_data_o[SB_RDY_B]; // [RL15] [RL19]
			op_fail_o    <= rd_data_o[SB_FAIL]; // [RL13]
			prog_err_o   <= rd_data_o[SB_PERR]; // [RL14]
			wp_off_o     <= rd_data_o[SB_WP_N]; // [RL16]
			status_odd_o <= |(rd_data_o & SB_ZERO_MASK); // [RL25]
		end
	end

	// ---------------------------------------------------------------
	// parameter page field check, same offsets in every copy
	// ---------------------------------------------------------------
	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			param_ok_o <= 1'b0;
		end else if (st_r == S_CMD1 && op_r == OP_PARAM) begin
			param_ok_o <= 1'b1;
		end else if (rd_valid_o && param_mode_r) begin
			for (int k = 0; k < PP_N; k++)
				if (rd_index_o[7:0] == PP_OFS[k] && rd_data_o != PP_VAL[k]) // [RL1] [RL2] [RL3] [RL4] [RL5] [RL6] [RL7] [RL8]
					param_ok_o <= 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// unique id: first clean copy wins, later copies ignored
	// ---------------------------------------------------------------
	logic [7:0] uid_mem [UID_LEN];
	logic       uid_good_r;

	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			uid_good_r <= 1'b0; uid_ok_o <= 1'b0; uid_code_o <= 128'h0;
			for (int k = 0; k < UID_LEN; k++) uid_mem[k] <= 8'h0;
		end else if (st_r == S_CMD1 && op_r == OP_UID) begin
			uid_ok_o <= 1'b0;
		end else if (rd_valid_o && op_r == OP_UID && !uid_ok_o) begin
			if (!rd_index_o[4]) begin
				uid_mem[rd_index_o[3:0]] <= rd_data_o; // [RL22]
				if (rd_index_o[3:0] == 4'h0) uid_good_r <= 1'b1;
			end else begin
				if ((uid_mem[rd_index_o[3:0]] ^ rd_data_o) != 8'hff) uid_good_r <= 1'b0; // [RL23]
				if (rd_index_o[4:0] == UID_PAIR_LAST && uid_good_r &&
					(uid_mem[rd_index_o[3:0]] ^ rd_data_o) == 8'hff) begin
					uid_ok_o <= 1'b1; // [RL23]
					for (int k = 0; k < UID_LEN; k++) uid_code_o[8*k +: 8] <= uid_mem[k];
				end
			end
		end
	end

	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) wp_n_o <= 1'b0;
		else wp_n_o <= 1'b1;
	end

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	otp_refuse_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i) // [RL21]
		(st_r == S_IDLE && req_valid_i && nsr_op_t'(req_op_i) == OP_STATUS_ENH && otp_mode_i)
		|=> req_refused_o && st_r == S_IDLE) else $error("enhanced status issued in otp mode");
	enh_rows_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i) // [RL18]
		($past(st_r) == S_ADDR && st_r == S_WAITT && op_r == OP_STATUS_ENH) |->
		$past(addr_i_r) + 2'h1 == ENH_ROW_CYC)
		else $error("enhanced status without three row cycles");
	status_hold_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i) // [RL12]
		(done_o && (op_r == OP_STATUS || op_r == OP_STATUS_ENH)) |-> status_mode_r)
		else $error("status mode lost before next command");
	arr_after_enh_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i) // [RL20]
		(st_r == S_IDLE && req_valid_i && nsr_op_t'(req_op_i) == OP_COLCHG && status_mode_r)
		|=> req_refused_o) else $error("array read without 00h after status");
	restart_col_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i) // [RL12]
		(rd_valid_o && op_r == OP_READ_MODE && $past(rd_first_r)) |-> rd_index_o == 16'h0)
		else $error("read mode did not restart at column zero");
	uid_pair_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i) // [RL23]
		$rose(uid_ok_o) |-> $past(rd_index_o[4:0]) == UID_PAIR_LAST && $past(rd_valid_o))
		else $error("uid accepted before a full pair");
	bus_turn_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
		!read_strobe_n_o |-> io_oe_n_o && we_n_o) else $error("host drives io while reading");
	ce_hold_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
		(st_r != S_IDLE && $past(st_r) != S_IDLE) |-> !ce_n_o) else $error("chip select dropped mid sequence");

	status_done_c: cover property (@(posedge mclk_i) disable iff (!reset_n_i) done_o && op_r == OP_STATUS);
	enh_done_c:    cover property (@(posedge mclk_i) disable iff (!reset_n_i) done_o && op_r == OP_STATUS_ENH);
	param_done_c:  cover property (@(posedge mclk_i) disable iff (!reset_n_i) done_o && op_r == OP_PARAM && param_ok_o);
	uid_ok_c:      cover property (@(posedge mclk_i) disable iff (!reset_n_i) $rose(uid_ok_o));

endmodule // nsr_host

// ==== verification/nsr_dev_model.sv ====
module nsr_dev_model
	import nsr_pkg::*;
#(
	parameter int IO_W    = 8,
	parameter int BUSY_NS = 800
) (
	input  wire logic            ce_n_i,          // chip select, low active
	input  wire logic            cle_i,           // command latch
	input  wire logic            ale_i,           // address latch
	input  wire logic            we_n_i,          // write strobe, low active
	input  wire logic            read_strobe_n_i, // read strobe, low active
	input  wire logic            wp_n_i,          // write protect, low active
	input  wire logic [IO_W-1:0] io_i,            // bus from host
	output logic      [IO_W-1:0] io_o,            // bus to host
	output logic                 ready_busy_n_o,  // high when ready
	input  wire logic            busy_i,          // array operation running
	input  wire logic [1:0]      fail_i,          // per plane failure
	input  wire logic [1:0]      perr_i,          // per plane program error
	input  wire logic            pp_bad_i,        // corrupt parameter byte 84
	input  wire logic [1:0]      uid_bad_i,       // 1: first copy bad, 2: all bad
	input  wire logic [127:0]    uid_i            // unique code
);
	timeunit 1ns;
	timeprecision 1ns;

	logic [7:0]  cmd_r      = 8'h00;
	logic [7:0]  last_r     = 8'h00;
	logic [7:0]  dout;
	logic [7:0]  st_w;
	logic [15:0] col_r      = 16'h0;
	logic [1:0]  acnt_r     = 2'h0;
	logic        st_mode_r  = 1'b0;
	logic        enh_r      = 1'b0;
	logic        plane_r    = 1'b0;
	logic        uid_src_r  = 1'b0;
	logic        int_busy_r = 1'b0;

	// ---------------------------------------------------------------
	// page contents
	// ---------------------------------------------------------------
	function automatic logic [7:0] pp_byte(input logic [15:0] c);
		logic [7:0] v;
		case (c[7:0])
			8'h54, 8'h5c: v = 8'h40;
			8'h57, 8'h64, 8'h86: v = 8'h02;
			8'h5a, 8'h61, 8'h87: v = 8'h10;
			8'h67: v = 8'h50;
			8'h6b, 8'h71: v = 8'h01;
			8'h85: v = 8'hbc;
			8'h88: v = 8'h27;
			8'h89: v = 8'h19;
			8'h8b: v = 8'h46;
			default: v = 8'h00;
		endcase
		if (pp_bad_i && c == 16'h0054)
			v = ~v;
		return v;
	endfunction

	function automatic logic [7:0] uid_byte(input logic [15:0] c);
		logic [7:0] v;
		v = uid_i[8*c[3:0] +: 8];
		if (c[4])
			v = ~v;
		else if (c[3:0] == 4'h0 && (uid_bad_i == 2'h2 || (uid_bad_i == 2'h1 && c[8:5] == 4'h0)))
			v = v ^ 8'h01;
		return v;
	endfunction

	// ---------------------------------------------------------------
	// output side
	// ---------------------------------------------------------------
	assign ready_busy_n_o = ~(busy_i | int_busy_r);
	assign st_w = {wp_n_i, ready_busy_n_o, ready_busy_n_o, 3'h0,
		enh_r ? perr_i[plane_r] : |perr_i, enh_r ? fail_i[plane_r] : |fail_i};
	always_comb begin
		dout = st_mode_r ? st_w : (uid_src_r ? uid_byte(col_r) : pp_byte(col_r));
	end
	// status is live while the strobe is low; a released bus shows no stale byte
	assign io_o = (!ce_n_i && !read_strobe_n_i) ? IO_W'(dout) : ~IO_W'(last_r);

	always @(posedge read_strobe_n_i) begin
		last_r <= dout;
		if (!ce_n_i && !st_mode_r)
			col_r <= col_r + 16'h1;
	end

	// ---------------------------------------------------------------
	// command and address latch
	// ---------------------------------------------------------------
	always @(posedge we_n_i) if (!ce_n_i) begin
		if (cle_i) begin
			cmd_r <= io_i[7:0];
			acnt_r <= 2'h0;
			case (io_i[7:0])
				CMD_STATUS: begin st_mode_r <= 1'b1; enh_r <= 1'b0; end
				CMD_STATUS_ENH: begin st_mode_r <= 1'b1; enh_r <= 1'b1; end
				CMD_PARAM, CMD_UID: begin
					st_mode_r <= 1'b0;
					col_r <= 16'h0;
					uid_src_r <= (io_i[7:0] == CMD_UID);
				end
				CMD_READ_MODE: begin st_mode_r <= 1'b0; col_r <= 16'h0; end
				CMD_COLCHG_END: st_mode_r <= 1'b0;
				default: ;
			endcase
		end else if (ale_i) begin
			acnt_r <= acnt_r + 2'h1;
			if (cmd_r == CMD_STATUS_ENH && acnt_r == 2'h0)
				plane_r <= io_i[6];
			if (cmd_r == CMD_COLCHG)
				col_r[8*acnt_r +: 8] <= io_i[7:0];
			if (cmd_r == CMD_PARAM || cmd_r == CMD_UID) begin
				int_busy_r <= 1'b1;
				int_busy_r <= #(BUSY_NS) 1'b0;
			end
		end
	end
endmodule // nsr_dev_model

// ==== verification/nsr_tb.sv ====
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin \
	$display("ERROR %s expected %0h seen %0h", nm, e, g); err_count++; end end

module tb
	import nsr_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	logic         mclk_i = 1'b0, reset_n_i = 1'b0, req_valid_i = 1'b0, otp_mode_i = 1'b0;
	logic         busy = 1'b0, pp_bad = 1'b0;
	logic [2:0]   req_op_i = 3'h0;
	logic [23:0]  req_row_i = 24'h0;
	logic [15:0]  req_col_i = 16'h0, req_len_i = 16'h0, rd_index_o;
	logic [1:0]   fail = 2'h0, perr = 2'h0, uid_bad = 2'h0;
	logic [127:0] uid = 128'h0, uid_code_o;
	logic [7:0]   rd_data_o, status_o, exp_st, io_o, io_i;
	logic         req_ready_o, req_refused_o, rd_valid_o, done_o, dev_ready_o, op_fail_o, prog_err_o;
	logic         wp_off_o, status_odd_o, param_ok_o, uid_ok_o, ce_n_o, cle_o, ale_o, we_n_o;
	logic         read_strobe_n_o, wp_n_o, io_oe_n_o, ready_busy_n;
	int           err_count = 0, checks_done = 0, seed = 32'hb755, kind = 4, exp_idx = 0, nbytes = 0;
	logic [31:0]  r;

	nsr_host #(.IO_W(8)) nsr_host_inst (.mclk_i, .reset_n_i, .req_valid_i, .req_op_i, .req_row_i, .req_col_i,
		.req_len_i, .otp_mode_i, .req_ready_o, .req_refused_o, .rd_data_o, .rd_valid_o, .rd_index_o, .done_o,
		.status_o, .dev_ready_o, .op_fail_o, .prog_err_o, .wp_off_o, .status_odd_o, .param_ok_o, .uid_ok_o,
		.uid_code_o, .ce_n_o, .cle_o, .ale_o, .we_n_o, .read_strobe_n_o, .wp_n_o, .io_i, .io_o, .io_oe_n_o,
		.ready_busy_n_i(ready_busy_n));

	nsr_dev_model #(.IO_W(8), .BUSY_NS(800)) nsr_dev_model_inst (.ce_n_i(ce_n_o), .cle_i(cle_o), .ale_i(ale_o),
		.we_n_i(we_n_o), .read_strobe_n_i(read_strobe_n_o), .wp_n_i(wp_n_o), .io_i(io_o), .io_o(io_i),
		.ready_busy_n_o(ready_busy_n), .busy_i(busy), .fail_i(fail), .perr_i(perr), .pp_bad_i(pp_bad),
		.uid_bad_i(uid_bad), .uid_i(uid));

	always #25 mclk_i = ~mclk_i;

	// ---------------------------------------------------------------
	// reference and byte monitor
	// ---------------------------------------------------------------
	function automatic logic [7:0] st_exp(input int pl); // pl below zero: all planes
		return {1'b1, ~busy, ~busy, 3'h0, pl < 0 ? |perr : perr[pl], pl < 0 ? |fail : fail[pl]};
	endfunction

	always @(posedge mclk_i) if (rd_valid_o === 1'b1) begin
		if (kind >= 2) `CHK("index", exp_idx[15:0], rd_index_o)
		if (kind < 2) `CHK("status", exp_st, rd_data_o)
		if (kind == 2 && !pp_bad)
			for (int i = 0; i < PP_N; i++)
				if (rd_index_o[7:0] == PP_OFS[i]) `CHK("param", PP_VAL[i], rd_data_o)
		exp_idx++;
		nbytes++;
	end

	// ---------------------------------------------------------------
	// request driver
	// ---------------------------------------------------------------
	task automatic run_op(input logic [2:0] op, input logic [23:0] row, input logic [15:0] col, input int len,
		input int k, input logic ref_e);
		int   n;
		logic rf;
		n = 0;
		kind = k;
		nbytes = 0;
		exp_idx = (op == 3'h4) ? int'(col) : 0;
		do begin @(posedge mclk_i); n++; end while (req_ready_o !== 1'b1 && n < 1000);
		req_op_i <= op;
		req_row_i <= row;
		req_col_i <= col;
		req_len_i <= 16'(len);
		req_valid_i <= 1'b1;
		@(posedge mclk_i);
		req_valid_i <= 1'b0;
		n = 0;
		do begin @(posedge mclk_i); n++; end while (done_o !== 1'b1 && req_refused_o !== 1'b1 && n < 20000);
		rf = req_refused_o;
		@(posedge mclk_i);
		`CHK("finished", 1'b1, n < 20000)
		`CHK("refused", ref_e, rf)
		`CHK("bytes", ref_e ? 0 : len, nbytes)
		if (k < 2 && !ref_e) begin
			`CHK("status_o", exp_st, status_o)
			`CHK("flags", {exp_st[7], exp_st[6] & exp_st[5], exp_st[1:0], 1'b0},
				{wp_off_o, dev_ready_o, prog_err_o, op_fail_o, status_odd_o})
		end
	endtask

	task automatic end_of_test();
		$display("checks_done %0d err_count %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// ---------------------------------------------------------------
	// scenarios
	// ---------------------------------------------------------------
	initial begin
		uid = {$random(seed), $random(seed), $random(seed), $random(seed)};
		repeat (10) @(posedge mclk_i);
		reset_n_i <= 1'b1;
		repeat (2) @(posedge mclk_i);
		// plain and per-plane status, busy or ready, random results
		for (int i = 0; i < 9; i++) begin
			r = $random(seed);
			fail <= r[1:0];
			perr <= r[3:2];
			busy <= r[4];
			@(posedge mclk_i);
			exp_st = st_exp(i % 3 - 1);
			run_op(i % 3 == 0 ? 3'h0 : 3'h1, {r[31:15], i % 3 == 2, r[5:0]}, 16'h0, 1, i % 3 == 0 ? 0 : 1, 1'b0);
		end
		busy <= 1'b0;
		otp_mode_i <= 1'b1;
		run_op(3'h1, 24'h0, 16'h0, 1, 4, 1'b1);
		otp_mode_i <= 1'b0;
		run_op(3'h2, 24'h0, 16'h0, 300, 2, 1'b0);
		`CHK("param_ok", 1'b1, param_ok_o)
		run_op(3'h4, 24'h0, 16'h0085, 8, 2, 1'b0);
		exp_st = st_exp(-1);
		run_op(3'h0, 24'h0, 16'h0, 1, 0, 1'b0);
		run_op(3'h4, 24'h0, 16'h0010, 4, 2, 1'b1);
		run_op(3'h5, 24'h0, 16'h0, 4, 2, 1'b0);
		pp_bad <= 1'b1;
		run_op(3'h2, 24'h0, 16'h0, 100, 2, 1'b0);
		`CHK("param_bad", 1'b0, param_ok_o)
		pp_bad <= 1'b0;
		// good copy, first copy broken, every copy broken
		for (int b = 0; b < 3; b++) begin
			uid_bad <= 2'(b);
			run_op(3'h3, 24'h0, 16'h0, b == 2 ? 512 : 64, 3, 1'b0);
			`CHK("uid_ok", b != 2, uid_ok_o)
			if (b < 2) `CHK("uid", uid, uid_code_o)
		end
		end_of_test();
	end

	initial begin
		#(20000 * 50);
		err_count++;
		end_of_test();
	end
endmodule // tb
